// >>> hdl/arc_pkg.sv
package arc_pkg;

   // Register map, 8-bit data, byte addresses
   localparam logic [7:0] REG_CHAN_BASE  = 8'h00;
   localparam logic [7:0] REG_CFG_ONE    = 8'h08;
   localparam logic [7:0] REG_CFG_TWO    = 8'h09;
   localparam logic [7:0] REG_RES_BASE   = 8'h10;
   localparam logic [7:0] REG_CMP1_HIGH  = 8'h20;
   localparam logic [7:0] REG_CMP1_LOW   = 8'h21;
   localparam logic [7:0] REG_CMP2_HIGH  = 8'h22;
   localparam logic [7:0] REG_CMP2_LOW   = 8'h23;
   localparam logic [7:0] REG_STAT_TWO   = 8'h24;

   // Channel control fields
   localparam int CC_FLAG_BIT = 7;
   localparam int CC_DIFF_BIT = 5;
   localparam logic [4:0] CHAN_OFF = 5'h1f;
   // Config one fields
   localparam int CF1_DIV_LSB   = 5;
   localparam int CF1_LONG_BIT  = 4;
   localparam int CF1_MODE_LSB  = 2;
   localparam int CF1_CLK_LSB   = 0;
   // Config two fields
   localparam int CF2_ACK_BIT   = 3;
   localparam int CF2_HS_BIT    = 2;
   localparam int CF2_LSTS_LSB  = 0;
   // Status/control two fields
   localparam int SC2_ACT_BIT   = 7;
   localparam int SC2_TRG_BIT   = 6;
   localparam int SC2_CFE_BIT   = 5;
   localparam int SC2_CGT_BIT   = 4;
   localparam int SC2_CREN_BIT  = 3;
   localparam int SC2_REF_LSB   = 0;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_CHAN = 8'h1f;

   // Converter clock cycle counts
   localparam logic [5:0] SHORT_SAMPLE_CYCLES = 6'd4;
   localparam logic [5:0] LONG_SAMPLE_00      = 6'd24;
   localparam logic [5:0] LONG_SAMPLE_01      = 6'd16;
   localparam logic [5:0] LONG_SAMPLE_10      = 6'd10;
   localparam logic [5:0] LONG_SAMPLE_11      = 6'd6;
   localparam logic [5:0] HIGH_SPEED_EXTRA    = 6'd4;
   localparam logic [5:0] CONVERT_CYCLES      = 6'd20;

   typedef enum logic [1:0] {
      CLK_BUS      = 2'b00,
      CLK_BUS_HALF = 2'b01,
      CLK_ALT      = 2'b10,
      CLK_ASYNC    = 2'b11
   } arc_clk_e;

   typedef enum logic [1:0] {
      REF_DEFAULT  = 2'b00,
      REF_ALT      = 2'b01,
      REF_BANDGAP  = 2'b10,
      REF_RESERVED = 2'b11
   } arc_ref_e;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV   = 2'b10
   } arc_state_e;

   // Command to the analog converter core
   typedef struct packed {
      logic       start;
      logic       sampling;
      logic       converting;
      logic [4:0] channel;
      logic       diff;
      logic [1:0] mode;
      logic [1:0] reference_select;
      logic       highSpeed;
   } arc_core_s;

   // Register bus request
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } arc_bus_s;

endpackage

// >>> hdl/arc_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module arc_adc_ctrl
   import arc_pkg::*;
#(
   parameter int NUM_CHAN = 2
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Register port
   input  wire arc_pkg::arc_bus_s bus,
   output var  logic [7:0]        rdData,
   // Hardware trigger source
   input  wire logic [NUM_CHAN-1:0] hardwareTriggerSelectIn,
   input  wire logic              hardwareTriggerIn,
   // Clock sources
   input  wire logic              alternateClock,
   input  wire logic              internalAsyncClock,
   output var  logic              asyncClockEnable,
   output var  logic              converterClockTick,
   // Converter core
   output var  arc_pkg::arc_core_s core,
   input  wire logic [15:0]       coreResult,
   // Status
   output var  logic              conversionActive
);
   import arc_pkg::*;

   localparam int IDX_W = (NUM_CHAN > 1) ? $clog2(NUM_CHAN) : 1;

   // Register storage
   logic [7:0]  chanCtrl_r [NUM_CHAN];
   logic [15:0] result_r   [NUM_CHAN];
   logic [NUM_CHAN-1:0] lock_r;
   logic [7:0]  cfgOne_r;
   logic [7:0]  cfgTwo_r;
   logic [15:0] cmpOne_r;
   logic [15:0] cmpTwo_r;
   logic [6:0]  statCtl_r;

   // Sequencer
   arc_state_e  state_r;
   logic [5:0]  cnt_r;
   logic [IDX_W-1:0] actIdx_r;
   logic [IDX_W-1:0] hwIdx_r;

   // Synchronisers
   logic [NUM_CHAN-1:0] hwSelS1_r, hwSelS2_r;
   logic        trigS1_r, trigS2_r, trigS3_r;
   logic        altS1_r, altS2_r, altS3_r;
   logic        ackS1_r, ackS2_r, ackS3_r;
   logic        halfTgl_r;
   logic [2:0]  divCnt_r;
   logic        asyncRun_r;

   // Decoded controls
   logic        trigHw, cmpEn, cmpGt, cmpRange;
   logic [1:0]  clkSel, modeSel, divSel;
   logic        actDiff;
   logic        srcTick, convTick;
   logic        trigRise;
   logic        wrChanA, startSw, startHw, abortWr, doneEv;
   logic [5:0]  sampleLen, lastCnt;
   logic [15:0] fmtRes, fmtOne, fmtTwo;
   logic        cmpPass, storeOk;
   logic signed [16:0] r, a, b;
   logic [NUM_CHAN-1:0] wrChan, rdHigh, rdLow;

   assign trigHw   = statCtl_r[SC2_TRG_BIT];
   assign cmpEn    = statCtl_r[SC2_CFE_BIT];
   assign cmpGt    = statCtl_r[SC2_CGT_BIT];
   assign cmpRange = statCtl_r[SC2_CREN_BIT];
   assign clkSel   = cfgOne_r[CF1_CLK_LSB +: 2];
   assign modeSel  = cfgOne_r[CF1_MODE_LSB +: 2];
   assign divSel   = cfgOne_r[CF1_DIV_LSB +: 2];
   assign actDiff  = chanCtrl_r[actIdx_r][CC_DIFF_BIT];

   // Right-justified result with zero or sign fill above the top bit
   function automatic logic [15:0] fmtVal(input logic [15:0] raw,
                                          input logic [1:0]  mode,
                                          input logic        diff);
      logic [3:0]  msb;
      logic [15:0] mask;
      unique case (mode)
         2'b00: msb = diff ? 4'd8  : 4'd7;
         2'b01: msb = diff ? 4'd12 : 4'd11;
         2'b10: msb = diff ? 4'd10 : 4'd9;
         2'b11: msb = 4'd15;
      endcase
      mask = 16'hffff >> (4'd15 - msb);
      if (diff && raw[msb]) begin
         fmtVal = raw | ~mask;
      end else begin
         fmtVal = raw & mask;
      end
   endfunction

   // Bus decode per channel
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         wrChan[i] = bus.wrEn && (bus.addr == REG_CHAN_BASE + 8'(i));
         rdHigh[i] = bus.rdEn && (bus.addr == REG_RES_BASE + 8'(2 * i));
         rdLow[i]  = bus.rdEn && (bus.addr == REG_RES_BASE + 8'(2 * i + 1));
      end
   end

   // Input synchronisers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hwSelS1_r <= '0;
         hwSelS2_r <= '0;
         trigS1_r  <= 1'b0;
         trigS2_r  <= 1'b0;
         trigS3_r  <= 1'b0;
         altS1_r   <= 1'b0;
         altS2_r   <= 1'b0;
         altS3_r   <= 1'b0;
         ackS1_r   <= 1'b0;
         ackS2_r   <= 1'b0;
         ackS3_r   <= 1'b0;
      end else begin
         hwSelS1_r <= hardwareTriggerSelectIn;
         hwSelS2_r <= hwSelS1_r;
         trigS1_r  <= hardwareTriggerIn;
         trigS2_r  <= trigS1_r;
         trigS3_r  <= trigS2_r;
         altS1_r   <= alternateClock;
         altS2_r   <= altS1_r;
         altS3_r   <= altS2_r;
         ackS1_r   <= internalAsyncClock;
         ackS2_r   <= ackS1_r;
         ackS3_r   <= ackS2_r;
      end
   end

   assign trigRise = trigS2_r && !trigS3_r;

   // Clock source selection and divide
   always_comb begin
      unique case (arc_clk_e'(clkSel))
         CLK_BUS:      srcTick = 1'b1;
         CLK_BUS_HALF: srcTick = halfTgl_r;
         CLK_ALT:      srcTick = altS2_r && !altS3_r;
         CLK_ASYNC:    srcTick = asyncRun_r && ackS2_r && !ackS3_r;
      endcase
   end

   assign convTick = srcTick && ((divCnt_r & ((3'd1 << divSel) - 3'd1)) ==
                                 ((3'd1 << divSel) - 3'd1));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         halfTgl_r          <= 1'b0;
         divCnt_r           <= 3'd0;
         asyncRun_r         <= 1'b0;
         asyncClockEnable   <= 1'b0;
         converterClockTick <= 1'b0;
      end else begin
         halfTgl_r <= !halfTgl_r;
         if (srcTick) begin
            divCnt_r <= divCnt_r + 3'd1;
         end
         asyncRun_r <= cfgTwo_r[CF2_ACK_BIT] ||
                       (clkSel == CLK_ASYNC && state_r != ST_IDLE);
         asyncClockEnable   <= cfgTwo_r[CF2_ACK_BIT] ||
                               (clkSel == CLK_ASYNC && state_r != ST_IDLE);
         converterClockTick <= convTick && state_r != ST_IDLE && !abortWr;
      end
   end

   // Sample length and conversion length
   always_comb begin
      if (cfgOne_r[CF1_LONG_BIT]) begin
         unique case (cfgTwo_r[CF2_LSTS_LSB +: 2])
            2'b00: sampleLen = LONG_SAMPLE_00;
            2'b01: sampleLen = LONG_SAMPLE_01;
            2'b10: sampleLen = LONG_SAMPLE_10;
            2'b11: sampleLen = LONG_SAMPLE_11;
         endcase
      end else begin
         sampleLen = SHORT_SAMPLE_CYCLES;
      end
      lastCnt = CONVERT_CYCLES +
                (cfgTwo_r[CF2_HS_BIT] ? HIGH_SPEED_EXTRA : 6'd0);
   end

   // Start, abort and completion events
   assign wrChanA = wrChan[0];
   assign startSw = wrChanA && !trigHw && bus.wrData[4:0] != CHAN_OFF;
   assign startHw = trigHw && trigRise &&
                    chanCtrl_r[hwIdx_r][4:0] != CHAN_OFF;
   assign abortWr = state_r != ST_IDLE && wrChan[actIdx_r];
   assign doneEv  = state_r == ST_CONV && convTick &&
                    cnt_r == lastCnt - 6'd1 && !abortWr;

   // Result and compare formatting
   always_comb begin
      fmtRes = fmtVal(coreResult, modeSel, actDiff);
      fmtOne = fmtVal(cmpOne_r, modeSel, actDiff);
      fmtTwo = fmtVal(cmpTwo_r, modeSel, actDiff);
      r = {actDiff & fmtRes[15], fmtRes};
      a = {actDiff & fmtOne[15], fmtOne};
      b = {actDiff & fmtTwo[15], fmtTwo};
      if (!cmpRange) begin
         cmpPass = cmpGt ? (r >= a) : (r < a);
      end else if (a <= b) begin
         cmpPass = cmpGt ? (r >= a && r <= b) : (r < a || r > b);
      end else begin
         cmpPass = cmpGt ? (r >= a || r <= b) : (r < a && r > b);
      end
      storeOk = !cmpEn || cmpPass;
   end

   // Sequencer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r  <= ST_IDLE;
         cnt_r    <= 6'd0;
         actIdx_r <= '0;
      end else if (startSw) begin
         state_r  <= ST_SAMPLE;
         cnt_r    <= 6'd0;
         actIdx_r <= '0;
      end else if (abortWr || doneEv) begin
         state_r <= ST_IDLE;
      end else if (state_r == ST_IDLE && startHw) begin
         state_r  <= ST_SAMPLE;
         cnt_r    <= 6'd0;
         actIdx_r <= hwIdx_r;
      end else if (convTick) begin
         unique case (state_r)
            ST_IDLE: cnt_r <= 6'd0;
            ST_SAMPLE: begin
               if (cnt_r == sampleLen - 6'd1) begin
                  state_r <= ST_CONV;
                  cnt_r   <= 6'd0;
               end else begin
                  cnt_r <= cnt_r + 6'd1;
               end
            end
            ST_CONV: cnt_r <= cnt_r + 6'd1;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Hardware channel select latch
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hwIdx_r <= '0;
      end else begin
         for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (hwSelS2_r[i]) begin
               hwIdx_r <= IDX_W'(i);
            end
         end
      end
   end

   // Per-channel control, result and lock
   generate
      for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
         logic eightSe;
         logic doneHere;
         assign eightSe  = modeSel == 2'b00 && !chanCtrl_r[g][CC_DIFF_BIT];
         assign doneHere = doneEv && actIdx_r == IDX_W'(g);

         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               chanCtrl_r[g] <= RESET_CHAN;
            end else begin
               if (wrChan[g]) begin
                  chanCtrl_r[g][6:0] <= {1'b0, bus.wrData[5:0]};
               end
               if (doneHere && storeOk) begin
                  chanCtrl_r[g][CC_FLAG_BIT] <= 1'b1;
               end else if (wrChan[g] || rdLow[g]) begin
                  chanCtrl_r[g][CC_FLAG_BIT] <= 1'b0;
               end
            end
         end

         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               result_r[g] <= 16'h0000;
            end else if (doneHere && storeOk && !lock_r[g]) begin
               result_r[g] <= fmtRes;
            end
         end

         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               lock_r[g] <= 1'b0;
            end else if (rdLow[g] || eightSe) begin
               lock_r[g] <= 1'b0;
            end else if (rdHigh[g]) begin
               lock_r[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // Shared configuration registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cfgOne_r  <= RESET_BYTE;
         cfgTwo_r  <= RESET_BYTE;
         cmpOne_r  <= 16'h0000;
         cmpTwo_r  <= 16'h0000;
         statCtl_r <= 7'h00;
      end else if (bus.wrEn) begin
         unique case (bus.addr)
            REG_CFG_ONE:   cfgOne_r         <= bus.wrData;
            REG_CFG_TWO:   cfgTwo_r         <= {4'h0, bus.wrData[3:0]};
            REG_CMP1_HIGH: cmpOne_r[15:8]   <= bus.wrData;
            REG_CMP1_LOW:  cmpOne_r[7:0]    <= bus.wrData;
            REG_CMP2_HIGH: cmpTwo_r[15:8]   <= bus.wrData;
            REG_CMP2_LOW:  cmpTwo_r[7:0]    <= bus.wrData;
            REG_STAT_TWO:  statCtl_r        <= {bus.wrData[6:3], 1'b0, bus.wrData[1:0]};
            default:       statCtl_r        <= statCtl_r;
         endcase
      end
   end

   // Read data, active status and core command
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdData <= 8'h00;
      end else if (bus.rdEn) begin
         rdData <= 8'h00;
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (bus.addr == REG_CHAN_BASE + 8'(i)) rdData <= chanCtrl_r[i];
            if (rdHigh[i]) rdData <= result_r[i][15:8];
            if (rdLow[i])  rdData <= result_r[i][7:0];
         end
         unique case (bus.addr)
            REG_CFG_ONE:   rdData <= cfgOne_r;
            REG_CFG_TWO:   rdData <= cfgTwo_r;
            REG_CMP1_HIGH: rdData <= cmpOne_r[15:8];
            REG_CMP1_LOW:  rdData <= cmpOne_r[7:0];
            REG_CMP2_HIGH: rdData <= cmpTwo_r[15:8];
            REG_CMP2_LOW:  rdData <= cmpTwo_r[7:0];
            REG_STAT_TWO:  rdData <= {state_r != ST_IDLE, statCtl_r};
            default:       ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         conversionActive <= 1'b0;
         core             <= '0;
      end else begin
         conversionActive <= (state_r != ST_IDLE && !abortWr) ||
                             startSw || (state_r == ST_IDLE && startHw);
         core.start      <= startSw || (state_r == ST_IDLE && startHw);
         core.sampling   <= state_r == ST_SAMPLE;
         core.converting <= state_r == ST_CONV;
         core.channel    <= chanCtrl_r[actIdx_r][4:0];
         core.diff       <= actDiff;
         core.mode       <= modeSel;
         core.highSpeed  <= cfgTwo_r[CF2_HS_BIT];
         unique case (arc_ref_e'(statCtl_r[SC2_REF_LSB +: 2]))
            REF_DEFAULT:  core.reference_select <= REF_DEFAULT;
            REF_ALT:      core.reference_select <= REF_ALT;
            REF_BANDGAP:  core.reference_select <= REF_BANDGAP;
            REF_RESERVED: core.reference_select <= REF_DEFAULT;
         endcase
      end
   end

endmodule // arc_adc_ctrl

`default_nettype wire

// >>> testbench/arc_adc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module arc_adc_ctrl_monitor
   import arc_pkg::*;
#(
   parameter int NUM_CHAN = 2
) (
   // Clock, reset and register port
   input wire logic                clk_sys,
   input wire logic                reset,
   input wire arc_pkg::arc_bus_s   bus,
   input wire logic [7:0]          rdData,
   // Trigger and clock sources
   input wire logic [NUM_CHAN-1:0] hardwareTriggerSelectIn,
   input wire logic                hardwareTriggerIn,
   input wire logic                alternateClock,
   input wire logic                internalAsyncClock,
   // Converter side
   input wire logic                asyncClockEnable,
   input wire logic                converterClockTick,
   input wire arc_pkg::arc_core_s  core,
   input wire logic [15:0]         coreResult,
   input wire logic                conversionActive
);
   logic [7:0] cfgOne_r;
   logic [7:0] cfgTwo_r;
   logic [7:0] statTwo_r;

   // Shadow copies of the written configuration
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cfgOne_r  <= 8'h00;
         cfgTwo_r  <= 8'h00;
         statTwo_r <= 8'h00;
      end else if (bus.wrEn) begin
         if (bus.addr == REG_CFG_ONE)
            cfgOne_r <= bus.wrData;
         if (bus.addr == REG_CFG_TWO)
            cfgTwo_r <= bus.wrData;
         if (bus.addr == REG_STAT_TWO)
            statTwo_r <= bus.wrData;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence s_sw_write;
      bus.wrEn && bus.addr == REG_CHAN_BASE && bus.wrData[4:0] != CHAN_OFF
         && !statTwo_r[SC2_TRG_BIT];
   endsequence
   sequence s_hw_arm;
      statTwo_r[SC2_TRG_BIT] && !conversionActive ##0 $rose(hardwareTriggerIn);
   endsequence

   property p_sw_start;
      s_sw_write |=> core.start;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("channel write did not start a conversion");
   property p_hw_start;
      s_hw_arm |-> ##[1:8] core.start;
   endproperty
   a_hw_start: assert property (p_hw_start)
      else $error("hardware trigger did not start a conversion");
   property p_start_active;
      core.start |-> conversionActive;
   endproperty
   a_start_active: assert property (p_start_active)
      else $error("active low at conversion start");
   property p_rose_start;
      $rose(conversionActive) |-> core.start;
   endproperty
   a_rose_start: assert property (p_rose_start)
      else $error("active rose without a start");
   property p_tick_active;
      converterClockTick |-> conversionActive;
   endproperty
   a_tick_active: assert property (p_tick_active)
      else $error("converter tick while idle");
   property p_async_on;
      cfgTwo_r[CF2_ACK_BIT] && $past(cfgTwo_r[CF2_ACK_BIT]) |-> asyncClockEnable;
   endproperty
   a_async_on: assert property (p_async_on)
      else $error("async clock off while enable bit set");
   property p_async_off;
      !cfgTwo_r[CF2_ACK_BIT] && !$past(cfgTwo_r[CF2_ACK_BIT])
         && cfgOne_r[1:0] != CLK_ASYNC && $past(cfgOne_r[1:0]) != CLK_ASYNC
         |-> !asyncClockEnable;
   endproperty
   a_async_off: assert property (p_async_off)
      else $error("async clock on while neither enabled nor selected");
   property p_ref_map;
      core.start |-> core.reference_select
         == ((statTwo_r[1:0] == REF_RESERVED) ? REF_DEFAULT : statTwo_r[1:0]);
   endproperty
   a_ref_map: assert property (p_ref_map)
      else $error("wrong reference at start");
   property p_hs_field;
      core.start |-> core.highSpeed == cfgTwo_r[CF2_HS_BIT];
   endproperty
   a_hs_field: assert property (p_hs_field)
      else $error("high speed flag differs from config");
endmodule // arc_adc_ctrl_monitor

bind arc_adc_ctrl arc_adc_ctrl_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (
   .clk_sys(clk_sys), .reset(reset), .bus(bus), .rdData(rdData),
   .hardwareTriggerSelectIn(hardwareTriggerSelectIn), .hardwareTriggerIn(hardwareTriggerIn),
   .alternateClock(alternateClock), .internalAsyncClock(internalAsyncClock),
   .asyncClockEnable(asyncClockEnable), .converterClockTick(converterClockTick),
   .core(core), .coreResult(coreResult), .conversionActive(conversionActive)
);
`default_nettype wire

// >>> testbench/arc_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
module arc_trig_model #(
   parameter int NUM_CHAN = 2
) (
   // Request from the bench
   input  wire logic                clk_sys,
   input  wire logic                go,
   input  wire logic [7:0]          sel,
   input  wire logic [7:0]          gap,
   // Trigger lines
   output var  logic [NUM_CHAN-1:0] hardwareTriggerSelectIn,
   output var  logic                hardwareTriggerIn
);
   initial begin
      hardwareTriggerSelectIn = '0;
      hardwareTriggerIn = 1'b0;
   end
   // Select pulse first, trigger after a chosen gap
   always begin
      @(posedge clk_sys iff go);
      #1 hardwareTriggerSelectIn[sel] = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 hardwareTriggerSelectIn = '0;
      repeat (gap) @(posedge clk_sys);
      #1 hardwareTriggerIn = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 hardwareTriggerIn = 1'b0;
   end
endmodule // arc_trig_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         failCount++; \
         $display("ERROR %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb;
   import arc_pkg::*;
   logic        clk_sys;
   logic        reset;
   arc_bus_s    bus;
   arc_core_s   core;
   logic [7:0]  rdData;
   logic [1:0]  hwSel;
   logic [15:0] coreResult;
   logic [7:0]  trigChan;
   logic [7:0]  gapV;
   logic [31:0] r;
   logic [7:0]  d;
   logic [1:0]  mdM;
   logic [1:0]  lsM;
   logic        hwTrig, alternate_clock, asyncClk, asyncEn, tick, active, go;
   logic        dfM, lngM, hsM, cmpOn, gtM, rgM, flagExp;
   logic [15:0] resExp [2];
   logic        lockd [2];
   logic [7:0]  rstA [6] = '{8'h00, 8'h09, 8'h20, 8'h24, 8'h10, 8'h30};
   int          cv1, cv2, seed, failCount, compares;

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always #37 alternate_clock = ~alternate_clock;
   // Internal oscillator only runs while enabled
   always #45 asyncClk = asyncEn ? ~asyncClk : asyncClk;

   arc_adc_ctrl #(.NUM_CHAN(2)) uut (
      .clk_sys(clk_sys), .reset(reset), .bus(bus), .rdData(rdData),
      .hardwareTriggerSelectIn(hwSel), .hardwareTriggerIn(hwTrig),
      .alternateClock(alternate_clock), .internalAsyncClock(asyncClk), .asyncClockEnable(asyncEn),
      .converterClockTick(tick), .core(core), .coreResult(coreResult),
      .conversionActive(active)
   );
   arc_trig_model #(.NUM_CHAN(2)) trigSrc (
      .clk_sys(clk_sys), .go(go), .sel(trigChan), .gap(gapV),
      .hardwareTriggerSelectIn(hwSel), .hardwareTriggerIn(hwTrig)
   );

   function automatic logic [15:0] fmt(input logic [15:0] raw);
      int w;
      logic [16:0] mk;
      w = (mdM == 2'b00) ? 8 : (mdM == 2'b01) ? 12 : (mdM == 2'b10) ? 10 : 16;
      w = (dfM && w < 16) ? w + 1 : w;
      mk = (17'h1 << w) - 17'h1;
      fmt = raw & mk[15:0];
      if (dfM && raw[w-1])
         fmt = fmt | ~mk[15:0];
   endfunction
   function automatic logic cmpOk(input int v);
      if (!rgM)
         return gtM ? v >= cv1 : v < cv1;
      if (cv1 <= cv2)
         return gtM ? (v >= cv1 && v <= cv2) : (v < cv1 || v > cv2);
      return gtM ? (v >= cv1 || v <= cv2) : (v < cv1 && v > cv2);
   endfunction

   task automatic wrapUp();
      $display("TB: compares=%0d mismatches=%0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      #1 bus = {1'b1, 1'b0, a, v};
      @(posedge clk_sys);
      #1 bus.wrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      #1 bus = {1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      #1 bus.rdEn = 1'b0;
      v = rdData;
   endtask
   task automatic cfg(input logic [7:0] one, input logic [7:0] two);
      wr(REG_CFG_ONE, one);
      wr(REG_CFG_TWO, two);
      {lngM, mdM} = one[4:2];
      {hsM, lsM} = two[2:0];
   endtask
   task automatic stat(input logic [7:0] v);
      wr(REG_STAT_TWO, v);
      {cmpOn, gtM, rgM} = v[5:3];
   endtask
   task automatic conv(input int p);
      int n;
      int k;
      int s;
      logic [15:0] v;
      v = 16'($random(seed));
      coreResult = v;
      k = 0;
      if (p == 0) begin
         wr(REG_CHAN_BASE, {2'b00, dfM, 5'h03});
      end else begin
         trigChan = 8'(p);
         @(posedge clk_sys);
         #1 go = 1'b1;
         @(posedge clk_sys);
         #1 go = 1'b0;
         while (active !== 1'b1 && k < 60) begin
            @(posedge clk_sys);
            #1 k++;
         end
      end
      n = 0;
      k = 0;
      while (active === 1'b1 && k < 2000) begin
         n += int'(tick === 1'b1);
         @(posedge clk_sys);
         #1 k++;
      end
      if (k == 0 || k == 2000) begin
         failCount++;
         $display("ERROR conversion expected end seen timeout");
         wrapUp();
      end
      s = !lngM ? SHORT_SAMPLE_CYCLES : lsM == 2'b00 ? LONG_SAMPLE_00 :
          lsM == 2'b01 ? LONG_SAMPLE_01 : lsM == 2'b10 ? LONG_SAMPLE_10 : LONG_SAMPLE_11;
      `CHK("ticks", s + CONVERT_CYCLES + (hsM ? HIGH_SPEED_EXTRA : 6'h0), n)
      `CHK("core", {p ? 5'h05 : 5'h03, dfM}, {core.channel, core.diff})
      v = fmt(v);
      flagExp = !cmpOn || cmpOk(int'(v));
      if (flagExp && !lockd[p])
         resExp[p] = v;
   endtask
   task automatic rdByte(input int p, input bit lo);
      rd(REG_RES_BASE + 8'(2 * p) + 8'(lo), d);
      if (lo)
         `CHK("resLow", resExp[p][7:0], d)
      else
         `CHK("resHigh", resExp[p][15:8], d)
      lockd[p] = !lo && !(mdM == 2'b00 && !dfM);
   endtask

   initial begin
      {seed, failCount, compares} = {32'd89, 32'd0, 32'd0};
      {reset, go, alternate_clock, asyncClk, dfM} = 5'h10;
      bus = '0;
      coreResult = 16'h0000;
      trigChan = 8'h00;
      gapV = 8'h01;
      resExp = '{16'h0000, 16'h0000};
      lockd = '{1'b0, 1'b0};
      repeat (3) @(posedge clk_sys);
      #1 reset = 1'b0;
      foreach (rstA[i]) begin
         rd(rstA[i], d);
         `CHK("resetVal", i == 0 ? RESET_CHAN : RESET_BYTE, d)
      end
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         wr(REG_CMP1_HIGH + 8'(i), r[7:0]);
         rd(REG_CMP1_HIGH + 8'(i), d);
         `CHK("cmpReg", r[7:0], d)
      end
      wr(REG_STAT_TWO, 8'hb9);
      rd(REG_STAT_TWO, d);
      `CHK("statTwo", 8'h39, d)
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         dfM = i[2];
         cfg({3'b000, r[4], i[1:0], i[2:1]}, {4'h0, i == 7, r[2:0]});
         stat({6'h00, i[1:0]});
         conv(0);
         rd(REG_CHAN_BASE, d);
         `CHK("flagSet", 1'b1, d[CC_FLAG_BIT])
         rdByte(0, 0);
         rdByte(0, 1);
         rd(REG_CHAN_BASE, d);
         `CHK("flagClr", 1'b0, d[CC_FLAG_BIT])
      end
      $display("test modes done");
      dfM = 1'b0;
      for (int j = 0; j < 2; j++) begin
         cfg(j ? 8'h00 : 8'h04, 8'h00);
         conv(0);
         rdByte(0, 0);
         conv(0);
         rdByte(0, 1);
         conv(0);
         rdByte(0, 0);
         rdByte(0, 1);
      end
      $display("test interlock done");
      cfg(8'h04, 8'h00);
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         cv1 = int'(r[11:0]);
         cv2 = int'(r[27:16]);
         wr(REG_CMP1_HIGH, r[15:8] & 8'h0f);
         wr(REG_CMP1_LOW, r[7:0]);
         wr(REG_CMP2_HIGH, r[31:24] & 8'h0f);
         wr(REG_CMP2_LOW, r[23:16]);
         stat({2'b00, i[2:0], 3'b000});
         conv(0);
         rd(REG_CHAN_BASE, d);
         `CHK("cmpFlag", flagExp, d[CC_FLAG_BIT])
         rdByte(0, 0);
         rdByte(0, 1);
      end
      $display("test compare done");
      stat(8'h40);
      wr(REG_CHAN_BASE + 8'h01, 8'h05);
      gapV = 8'(1 + r[2:0]);
      conv(1);
      rdByte(1, 0);
      rdByte(1, 1);
      rdByte(0, 1);
      $display("test hardware trigger done");
      wrapUp();
   end
endmodule // tb
`default_nettype wire
